// >>> hdl/ppec_pkg.sv
// Package of constants and carrier types for the paged parallel EEPROM host controller.
//
// Operation
// - Write starts on strobe or select low pulse, other low, gate high.
// - Each further byte within 150 us, otherwise programming begins.
// - Host keeps page address constant at every falling strobe of a load; the controller does not enforce this and strobes any address written.
// - Three command writes enable the lock after program cycle time.
// - Locked part accepts loads preceded by the three-write enable sequence.
// - Command writes follow page load timing and store no data.
// - With id row pin at high voltage, an extra 128-byte row maps in.
// - Toggle polling keeps one constant address across reads; the controller compares bit 6 of any two successive reads, at any address.
package ppec_pkg;

  // ----------------------------------------------------------------
  // Register map (Avalon-MM word addresses)
  // ----------------------------------------------------------------
  localparam logic [2:0] PPEC_REG_CMD    = 3'h0;
  localparam logic [2:0] PPEC_REG_ADDR   = 3'h1;
  localparam logic [2:0] PPEC_REG_WDATA  = 3'h2;
  localparam logic [2:0] PPEC_REG_RDATA  = 3'h3;
  localparam logic [2:0] PPEC_REG_STATUS = 3'h4;

  // Command codes written to the command register.
  localparam logic [2:0] PPEC_CMD_READ   = 3'h1;
  localparam logic [2:0] PPEC_CMD_LOAD   = 3'h2;
  localparam logic [2:0] PPEC_CMD_LOCK   = 3'h3;
  localparam logic [2:0] PPEC_CMD_UNLOCK = 3'h4;
  localparam logic [2:0] PPEC_CMD_PLOAD  = 3'h5;

  // Command sequence values; arbitrary defaults, set for the real part.
  localparam logic [16:0] PPEC_SEQ_A0 = 17'h0_4C21;
  localparam logic [16:0] PPEC_SEQ_A1 = 17'h0_3B12;
  localparam logic [7:0]  PPEC_SEQ_D0 = 8'h69;
  localparam logic [7:0]  PPEC_SEQ_D1 = 8'h96;
  localparam logic [7:0]  PPEC_SEQ_D_LOCK   = 8'hB4;
  localparam logic [7:0]  PPEC_SEQ_D_UNLOCK = 8'h4B;
  localparam logic [7:0]  PPEC_SEQ_D_UNL0   = 8'hD2;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int PPEC_CLK_MHZ       = 200;
  localparam int PPEC_STROBE_NS     = 100;
  localparam int PPEC_SETUP_NS      = 50;
  localparam int PPEC_ACCESS_NS     = 120;
  localparam int PPEC_LOAD_WIN_US   = 150;
  localparam int PPEC_PROG_MS       = 10;
  localparam int PPEC_PWRUP_MS      = 5;
  localparam int PPEC_STROBE_CYC = (PPEC_STROBE_NS * PPEC_CLK_MHZ + 999) / 1000;
  localparam int PPEC_SETUP_CYC  = (PPEC_SETUP_NS * PPEC_CLK_MHZ + 999) / 1000;
  localparam int PPEC_ACCESS_CYC = (PPEC_ACCESS_NS * PPEC_CLK_MHZ + 999) / 1000 + 2;
  localparam int PPEC_LOAD_WIN_CYC = PPEC_LOAD_WIN_US * PPEC_CLK_MHZ;
  localparam int PPEC_PROG_CYC     = PPEC_PROG_MS * 1000 * PPEC_CLK_MHZ;
  localparam int PPEC_PWRUP_CYC    = PPEC_PWRUP_MS * 1000 * PPEC_CLK_MHZ;
  localparam int PPEC_BYTES_PAGE   = 128;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        sel_n;
    logic        gate_n;
    logic        strobe_n;
    logic        id_row;
    logic [16:0] addr;
  } ppec_pins_s;

  typedef enum logic [2:0] {
    PPEC_IDLE   = 3'b000,
    PPEC_SETUP  = 3'b001,
    PPEC_PULSE  = 3'b010,
    PPEC_HOLD   = 3'b011,
    PPEC_RD     = 3'b100,
    PPEC_BUSY   = 3'b101
  } ppec_state_e;

endpackage

// >>> hdl/ppec_host.sv
// Host controller that drives a paged parallel EEPROM from Avalon-MM registers.
//
// The register offsets and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module ppec_host #(
  parameter int LOAD_WIN_CYC = ppec_pkg::PPEC_LOAD_WIN_CYC,
  parameter int PROG_CYC     = ppec_pkg::PPEC_PROG_CYC,
  parameter int PWRUP_CYC    = ppec_pkg::PPEC_PWRUP_CYC
) (
  // Clock and reset
  input  wire logic              i_sys_clk,
  input  wire logic              i_reset,
  // Avalon-MM slave
  input  wire logic [2:0]        i_avs_address,
  input  wire logic              i_avs_read,
  input  wire logic              i_avs_write,
  input  wire logic [31:0]       i_avs_writedata,
  output logic      [31:0]       o_avs_readdata,
  output logic                   o_avs_waitrequest,
  // Memory pins
  output ppec_pkg::ppec_pins_s   o_mem,
  input  wire logic [7:0]        i_mem_data,
  output logic      [7:0]        o_mem_data,
  output logic                   o_mem_data_oe
);
  import ppec_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  ppec_state_e state_reg, state_next;
  ppec_pins_s  pins_reg;
  logic [31:0] cnt_reg;
  logic [31:0] win_reg;
  logic [31:0] prog_reg;
  logic [31:0] pwr_reg;
  logic [7:0]  din_meta_reg, din_reg;
  logic [7:0]  rdata_reg, wdata_reg, dout_reg;
  logic [16:0] addr_reg;
  logic        id_reg, oe_reg;
  logic        loading_reg, is_rd_reg;
  logic [16:0] page_reg;
  logic [7:0]  nbytes_reg;
  logic [2:0]  seq_idx_reg;
  logic [2:0]  pend_reg;
  logic        lock_reg, err_reg, wait_reg;
  logic [31:0] rd_reg;
  logic [7:0]  prev_poll_reg;
  logic        poll_valid_reg;

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  wire busy_fsm   = (state_reg != PPEC_IDLE);
  wire pwr_ok     = (pwr_reg == 32'h0000_0000);
  wire prog_busy  = (prog_reg != 32'h0000_0000);
  wire sel_cmd    = (i_avs_address == PPEC_REG_CMD);
  wire sel_addr   = (i_avs_address == PPEC_REG_ADDR);
  wire sel_wdata  = (i_avs_address == PPEC_REG_WDATA);
  wire sel_rdata  = (i_avs_address == PPEC_REG_RDATA);
  wire sel_status = (i_avs_address == PPEC_REG_STATUS);
  wire cmd_wr     = i_avs_write && sel_cmd && !wait_reg;
  wire [2:0] cmd  = i_avs_writedata[2:0];
  // Loads are not refused while the memory programs; software waits on the status bits.
  wire cmd_ok     = !busy_fsm && pwr_ok && (pend_reg == 3'h0);
  wire same_page  = loading_reg && (addr_reg[16:7] == page_reg[16:7]) && (nbytes_reg < 8'(PPEC_BYTES_PAGE));
  wire win_done   = loading_reg && (win_reg == 32'h0000_0000);
  wire [7:0] seq_d = (seq_idx_reg == 3'h0 || seq_idx_reg == 3'h3) ? PPEC_SEQ_D0 :
                     (seq_idx_reg == 3'h1 || seq_idx_reg == 3'h4) ? PPEC_SEQ_D1 :
                     (seq_idx_reg == 3'h5) ? PPEC_SEQ_D_UNLOCK :
                     (pend_reg == PPEC_CMD_UNLOCK) ? PPEC_SEQ_D_UNL0 : PPEC_SEQ_D_LOCK;
  wire [16:0] seq_a = (seq_idx_reg == 3'h1 || seq_idx_reg == 3'h4) ? PPEC_SEQ_A1 : PPEC_SEQ_A0;
  wire in_seq   = (pend_reg == PPEC_CMD_LOCK) || (pend_reg == PPEC_CMD_UNLOCK) || (pend_reg == PPEC_CMD_PLOAD);
  wire new_seq  = (pend_reg == 3'h0) && cmd_wr &&
                  (cmd == PPEC_CMD_LOCK || cmd == PPEC_CMD_UNLOCK || cmd == PPEC_CMD_PLOAD);
  wire seq_last = (pend_reg == PPEC_CMD_UNLOCK) ? (seq_idx_reg == 3'h5) : (seq_idx_reg == 3'h2);
  // Busy also covers the idle gaps between the writes of a command sequence.
  wire [31:0] status_w = {24'h00_0000, 1'b0, lock_reg, err_reg,
                          loading_reg, prog_busy, !pwr_ok, busy_fsm || (pend_reg != 3'h0), wait_reg};
  wire [31:0] rd_mux = sel_rdata  ? {24'h00_0000, rdata_reg} :
                       sel_status ? status_w :
                       sel_addr   ? {15'h0000, addr_reg} :
                       sel_wdata  ? {24'h00_0000, wdata_reg} : 32'h0000_0000;
  // Data pin bit 6 toggling between two polls marks a running program cycle.
  wire toggling   = poll_valid_reg && (prev_poll_reg[6] != din_reg[6]);

  // ----------------------------------------------------------------
  // Pin sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      PPEC_IDLE:  if (pend_reg != 3'h0 || (cmd_wr && cmd_ok && cmd != 3'h0)) state_next = PPEC_SETUP;
      PPEC_SETUP: if (cnt_reg == 32'h0000_0000) state_next = is_rd_reg ? PPEC_RD : PPEC_PULSE;
      PPEC_PULSE: if (cnt_reg == 32'h0000_0000) state_next = PPEC_HOLD;
      PPEC_HOLD:  if (cnt_reg == 32'h0000_0000) state_next = PPEC_IDLE;
      PPEC_RD:    if (cnt_reg == 32'h0000_0000) state_next = PPEC_HOLD;
      default:    state_next = PPEC_IDLE;
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      state_reg     <= PPEC_IDLE;
      pins_reg      <= '{sel_n: 1'b1, gate_n: 1'b1, strobe_n: 1'b1, id_row: 1'b0, addr: 17'h0_0000};
      cnt_reg       <= 32'h0000_0000;
      win_reg       <= 32'h0000_0000;
      prog_reg      <= 32'h0000_0000;
      pwr_reg       <= 32'(PWRUP_CYC);
      din_meta_reg  <= 8'h00;
      din_reg       <= 8'h00;
      rdata_reg     <= 8'h00;
      wdata_reg     <= 8'h00;
      dout_reg      <= 8'h00;
      addr_reg      <= 17'h0_0000;
      id_reg        <= 1'b0;
      oe_reg        <= 1'b0;
      is_rd_reg     <= 1'b0;
      loading_reg   <= 1'b0;
      page_reg      <= 17'h0_0000;
      nbytes_reg    <= 8'h00;
      seq_idx_reg   <= 3'h0;
      pend_reg      <= 3'h0;
      lock_reg      <= 1'b0;
      err_reg       <= 1'b0;
      wait_reg      <= 1'b1;
      rd_reg        <= 32'h0000_0000;
      prev_poll_reg <= 8'h00;
      poll_valid_reg <= 1'b0;
    end else begin
      // Data pins from the memory are asynchronous to this clock.
      din_meta_reg <= i_mem_data;
      din_reg      <= din_meta_reg;
      state_reg    <= state_next;
      // Power-up lockout mirrors the memory's own write block.
      if (!pwr_ok) pwr_reg <= pwr_reg - 32'h0000_0001;
      if (prog_busy) prog_reg <= prog_reg - 32'h0000_0001;
      // Load window: expiry means the memory has begun programming.
      if (loading_reg && !win_done) win_reg <= win_reg - 32'h0000_0001;
      if (win_done) begin
        loading_reg <= 1'b0;
        prog_reg    <= 32'(PROG_CYC);
      end
      // Avalon: one wait cycle, then answer.
      wait_reg <= !(i_avs_read || i_avs_write) || !wait_reg;
      // Read data are latched one edge early so they stand while waitrequest is low.
      if (wait_reg && i_avs_read) rd_reg <= rd_mux;
      if (i_avs_write && !wait_reg) begin
        if (sel_addr) begin
          addr_reg <= i_avs_writedata[16:0];
          id_reg   <= i_avs_writedata[17];
        end
        if (sel_wdata) wdata_reg <= i_avs_writedata[7:0];
        if (sel_status && i_avs_writedata[5]) err_reg <= 1'b0;
        if (cmd_wr && !cmd_ok) err_reg <= 1'b1;
      end
      if (cnt_reg != 32'h0000_0000) cnt_reg <= cnt_reg - 32'h0000_0001;
      case (state_reg)
        PPEC_IDLE: begin
          if (pend_reg != 3'h0 || (cmd_wr && cmd_ok && cmd != 3'h0)) begin
            is_rd_reg <= (pend_reg == 3'h0) && (cmd == PPEC_CMD_READ);
            cnt_reg   <= 32'(PPEC_SETUP_CYC);
            // Address and gate settle first; gate high before any strobe.
            pins_reg.sel_n  <= 1'b1;
            pins_reg.gate_n <= 1'b1;
            pins_reg.id_row <= id_reg;
            if (in_seq || new_seq) begin
              pins_reg.addr <= seq_a;
              dout_reg      <= seq_d;
            end else begin
              pins_reg.addr <= addr_reg;
              dout_reg      <= wdata_reg;
            end
            if (new_seq) begin
              pend_reg    <= cmd;
              seq_idx_reg <= 3'h0;
            end
            oe_reg <= !((pend_reg == 3'h0) && (cmd == PPEC_CMD_READ));
          end
        end
        PPEC_SETUP: if (cnt_reg == 32'h0000_0000) begin
          pins_reg.sel_n <= 1'b0;
          cnt_reg        <= is_rd_reg ? 32'(PPEC_ACCESS_CYC) : 32'(PPEC_STROBE_CYC);
          if (is_rd_reg) pins_reg.gate_n <= 1'b0;
          else pins_reg.strobe_n <= 1'b0;
        end
        PPEC_PULSE: if (cnt_reg == 32'h0000_0000) begin
          // Strobe rises while data still drives, so the memory latches it here.
          pins_reg.strobe_n <= 1'b1;
          cnt_reg <= 32'(PPEC_SETUP_CYC);
          if (in_seq && !seq_last) begin
            seq_idx_reg <= seq_idx_reg + 3'h1;
          end else begin
            seq_idx_reg <= 3'h0;
            if (pend_reg == PPEC_CMD_LOCK || pend_reg == PPEC_CMD_UNLOCK) begin
              lock_reg <= (pend_reg == PPEC_CMD_LOCK);
              pend_reg <= 3'h0;
            end else if (pend_reg == PPEC_CMD_PLOAD) pend_reg <= PPEC_CMD_LOAD;
            else pend_reg <= 3'h0;
          end
          // Every strobe restarts the byte window of the open load.
          win_reg <= 32'(LOAD_WIN_CYC);
          if (!loading_reg || !same_page) begin
            page_reg   <= pins_reg.addr;
            nbytes_reg <= 8'h01;
          end else nbytes_reg <= nbytes_reg + 8'h01;
          loading_reg <= 1'b1;
        end
        PPEC_RD: if (cnt_reg == 32'h0000_0000) begin
          rdata_reg    <= din_reg;
          // Only bit 6 toggling marks busy; bit 7 against the last written byte is not checked.
          prev_poll_reg  <= din_reg;
          poll_valid_reg <= 1'b1;
          if (toggling) prog_reg <= 32'(PROG_CYC);
          else if (poll_valid_reg) prog_reg <= 32'h0000_0000;
          pins_reg.gate_n <= 1'b1;
          pins_reg.sel_n  <= 1'b1;
          cnt_reg <= 32'(PPEC_SETUP_CYC);
        end
        PPEC_HOLD: if (cnt_reg == 32'h0000_0000) begin
          pins_reg.sel_n <= 1'b1;
          oe_reg <= 1'b0;
        end
        default: begin
        end
      endcase
      if (pend_reg == PPEC_CMD_LOAD && state_reg == PPEC_IDLE) begin
        pins_reg.addr <= addr_reg;
        dout_reg      <= wdata_reg;
        pend_reg      <= 3'h0;
      end
    end
  end

  assign o_mem             = pins_reg;
  assign o_mem_data        = dout_reg;
  assign o_mem_data_oe     = oe_reg;
  assign o_avs_readdata    = rd_reg;
  assign o_avs_waitrequest = wait_reg;

endmodule
`default_nettype wire

// >>> bench/ppec_host_assertions.sv
// Checker on the memory pins of the EEPROM host controller.
`timescale 1ns/1ps
`default_nettype none
module ppec_host_assertions
  import ppec_pkg::*;
#(
  parameter int PWRUP_CYC = PPEC_PWRUP_CYC
) (
  // Clock and reset
  input wire logic                 i_sys_clk,
  input wire logic                 i_reset,
  // Memory pins
  input wire ppec_pkg::ppec_pins_s o_mem,
  input wire logic [7:0]           o_mem_data,
  input wire logic                 o_mem_data_oe
);
  // ----------------------------------------------------------------
  // Pulse and lockout counters
  // ----------------------------------------------------------------
  logic [31:0] lo_cnt_reg;
  logic [31:0] gl_cnt_reg;
  logic [31:0] pw_cnt_reg;
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      lo_cnt_reg <= 32'h0000_0000;
      gl_cnt_reg <= 32'h0000_0000;
      pw_cnt_reg <= 32'h0000_0000;
    end else begin
      lo_cnt_reg <= o_mem.strobe_n ? 32'h0000_0000 : lo_cnt_reg + 32'h0000_0001;
      gl_cnt_reg <= o_mem.gate_n ? 32'h0000_0000 : gl_cnt_reg + 32'h0000_0001;
      if (pw_cnt_reg < 32'(PWRUP_CYC)) pw_cnt_reg <= pw_cnt_reg + 32'h0000_0001;
    end
  end
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_WR_SELECTED: assert property (!o_mem.strobe_n |-> !o_mem.sel_n)
    else $error("strobe low without chip select");
  AST_WR_GATE_HIGH: assert property (!o_mem.strobe_n |-> o_mem.gate_n)
    else $error("strobe low while output gate low");
  AST_RD_CLEAN: assert property (!o_mem.gate_n |-> !o_mem.sel_n && o_mem.strobe_n && !o_mem_data_oe)
    else $error("read cycle with bad pin levels");
  AST_DRIVE_AFTER_FLOAT: assert property ($rose(o_mem_data_oe) |-> o_mem.gate_n && $past(o_mem.gate_n))
    else $error("host drove data before memory floated");
  AST_STROBE_WIDTH: assert property ($rose(o_mem.strobe_n) |-> lo_cnt_reg >= 32'(PPEC_STROBE_CYC))
    else $error("write strobe pulse too short");
  AST_ADDR_HELD: assert property (!o_mem.strobe_n |-> $stable(o_mem.addr))
    else $error("address moved during write strobe");
  AST_DATA_HELD: assert property (!o_mem.strobe_n |-> o_mem_data_oe && $stable(o_mem_data))
    else $error("write data not held during strobe");
  AST_PWRUP_WAIT: assert property (!o_mem.strobe_n |-> pw_cnt_reg >= 32'(PWRUP_CYC))
    else $error("write during power-up lockout");
  AST_ID_HELD: assert property (!o_mem.sel_n |-> $stable(o_mem.id_row))
    else $error("id row request moved while selected");
  AST_READ_WIDTH: assert property ($rose(o_mem.gate_n) |-> gl_cnt_reg >= 32'(PPEC_ACCESS_CYC))
    else $error("output gate low shorter than access time");
  COV_WRITE: cover property ($rose(o_mem.strobe_n));
  COV_READ: cover property ($rose(o_mem.gate_n));
  COV_ID_ROW: cover property (!o_mem.sel_n && o_mem.id_row);
endmodule
`default_nettype wire

// >>> bench/ppec_eeprom_model.sv
// Behavioural model of the paged parallel EEPROM seen by the host controller.
`timescale 1ns/1ps
`default_nettype none
module ppec_eeprom_model
  import ppec_pkg::*;
#(
  parameter int LOAD_NS  = 300,
  parameter int PROG_NS  = 600,
  parameter int PWRUP_NS = 60
) (
  // Pins
  input wire ppec_pkg::ppec_pins_s i_pins,
  input wire logic [7:0]           i_dq,
  output logic [7:0]               o_dq,
  output logic                     o_dq_oe,
  output logic                     o_locked
);
  bit [7:0]    mem [bit [17:0]];
  logic [25:0] pq [$];
  logic        busy, tog, en, un;
  logic [7:0]  last;
  logic [17:0] wa;
  time         t_last;
  int          i;
  wire we = !i_pins.sel_n && !i_pins.strobe_n && i_pins.gate_n;
  assign o_dq_oe = !i_pins.sel_n && !i_pins.gate_n && i_pins.strobe_n;
  initial begin
    busy = 0; tog = 0; o_locked = 0; last = 8'h00; o_dq = 8'h00; t_last = 0;
  end
  function automatic bit hit(int k, logic [16:0] a, logic [7:0] d);
    return k < pq.size() && pq[k][24:8] == a && pq[k][7:0] == d;
  endfunction
  always @(posedge we) wa = {i_pins.id_row, i_pins.addr};
  // Loads are ignored while programming; the window restarts on every byte.
  always @(negedge we) if (!busy && $time >= PWRUP_NS) begin
    pq.push_back({wa, i_dq});
    last = i_dq;
    t_last = $time;
  end
  always begin
    wait (pq.size() != 0);
    while ($time < t_last + LOAD_NS) #(t_last + LOAD_NS - $time);
    busy = 1;
    en = 0; un = 0; i = 0;
    while (i < pq.size()) begin
      if (hit(i, PPEC_SEQ_A0, PPEC_SEQ_D0) && hit(i+1, PPEC_SEQ_A1, PPEC_SEQ_D1) && hit(i+2, PPEC_SEQ_A0, PPEC_SEQ_D_UNL0)
          && hit(i+3, PPEC_SEQ_A0, PPEC_SEQ_D0) && hit(i+4, PPEC_SEQ_A1, PPEC_SEQ_D1)
          && hit(i+5, PPEC_SEQ_A0, PPEC_SEQ_D_UNLOCK)) begin
        un = 1; i += 6;
      end else if (hit(i, PPEC_SEQ_A0, PPEC_SEQ_D0) && hit(i+1, PPEC_SEQ_A1, PPEC_SEQ_D1)
                   && hit(i+2, PPEC_SEQ_A0, PPEC_SEQ_D_LOCK)) begin
        en = 1; i += 3;
      end else begin
        if (!o_locked || en || un) mem[pq[i][25:8]] = pq[i][7:0];
        i++;
      end
    end
    pq.delete();
    #(PROG_NS);
    if (en) o_locked = 1;
    if (un) o_locked = 0;
    busy = 0;
  end
  // Reads during programming return the poll pattern instead of the array.
  always @(posedge o_dq_oe) begin
    if (busy) begin
      o_dq = {~last[7], tog, last[5:0]};
      tog = ~tog;
    end else begin
      o_dq = mem.exists({i_pins.id_row, i_pins.addr}) ? mem[{i_pins.id_row, i_pins.addr}] : 8'hFF;
    end
  end
endmodule
`default_nettype wire

// >>> bench/tb_top.sv
// Testbench for the EEPROM host controller against the memory model.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ppec_pkg::*;
  localparam int LW = 50, PC = 200, PU = 20;
  logic i_sys_clk, i_reset, avs_read, avs_write, avs_waitrequest, host_oe, mem_oe, locked;
  logic [2:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [7:0]  host_d, mem_q, float_pat;
  ppec_pins_s  pins;
  int          n_errors, cmp_count;
  // Nobody driving: the line shows a pattern that changes every cycle.
  wire [7:0] bus = mem_oe ? mem_q : host_oe ? host_d : float_pat;
  ppec_host #(.LOAD_WIN_CYC(LW), .PROG_CYC(PC), .PWRUP_CYC(PU)) ppec_host_inst (
    .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_avs_address(avs_address), .i_avs_read(avs_read),
    .i_avs_write(avs_write), .i_avs_writedata(avs_writedata), .o_avs_readdata(avs_readdata),
    .o_avs_waitrequest(avs_waitrequest), .o_mem(pins), .i_mem_data(bus), .o_mem_data(host_d),
    .o_mem_data_oe(host_oe));
  ppec_eeprom_model ppec_eeprom_model_inst (.i_pins(pins), .i_dq(bus), .o_dq(mem_q), .o_dq_oe(mem_oe),
    .o_locked(locked));
  initial begin
    i_sys_clk = 0;
    forever #2.5 i_sys_clk = ~i_sys_clk;
  end
  always @(posedge i_sys_clk) float_pat <= ~float_pat;
  task check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task tally_and_finish();
    $display("errors=%0d compares=%0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task av(input logic wr, input logic [2:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge i_sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    if (n >= 100) check(32'h0000_0001, 32'h0000_0000);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task stat_wait(input logic [31:0] mask);
    int n;
    n = 0;
    do begin
      av(0, PPEC_REG_STATUS, 32'h0000_0000);
      n++;
    end while ((rd & mask) !== 32'h0000_0000 && n < 2000);
    if (n >= 2000) check(rd, 32'h0000_0000);
  endtask
  task op(input logic [2:0] cmd, input logic [17:0] a, input logic [7:0] d);
    av(1, PPEC_REG_ADDR, {14'h0000, a});
    av(1, PPEC_REG_WDATA, {24'h00_0000, d});
    av(1, PPEC_REG_CMD, {29'h0000_0000, cmd});
    stat_wait(32'h0000_0002);
  endtask
  task rd_byte(input logic [17:0] a, input logic [7:0] exp);
    stat_wait(32'h0000_001A);
    op(PPEC_CMD_READ, a, 8'h00);
    av(0, PPEC_REG_RDATA, 32'h0000_0000);
    check({24'h00_0000, rd[7:0]}, {24'h00_0000, exp});
  endtask
  initial begin
    repeat (60000) @(posedge i_sys_clk);
    check(32'h0000_0001, 32'h0000_0000);
    tally_and_finish();
  end
  initial begin
    float_pat = 8'h5A; n_errors = 0; cmp_count = 0; i_reset = 1;
    avs_read = 0; avs_write = 0; avs_address = 3'h0; avs_writedata = 32'h0000_0000;
    repeat (5) @(posedge i_sys_clk);
    i_reset <= 1'b0;
    av(0, PPEC_REG_STATUS, 32'h0000_0000);
    check({31'h0, rd[2]}, 32'h0000_0001);
    stat_wait(32'h0000_0004);
    op(PPEC_CMD_LOAD, 18'h0_0105, 8'h11);
    op(PPEC_CMD_LOAD, 18'h0_017F, 8'h22);
    op(PPEC_CMD_LOAD, 18'h0_0100, 8'h33);
    op(PPEC_CMD_LOAD, 18'h0_0105, 8'h44);
    rd_byte(18'h0_0105, 8'h44);
    rd_byte(18'h0_017F, 8'h22);
    rd_byte(18'h0_0100, 8'h33);
    rd_byte(18'h0_0101, 8'hFF);
    av(1, PPEC_REG_ADDR, 32'h0000_0110);
    av(1, PPEC_REG_WDATA, 32'h0000_0055);
    av(1, PPEC_REG_CMD, {29'h0, PPEC_CMD_LOAD});
    av(1, PPEC_REG_CMD, {29'h0, PPEC_CMD_LOAD});
    av(0, PPEC_REG_STATUS, 32'h0000_0000);
    check({31'h0, rd[5]}, 32'h0000_0001);
    av(1, PPEC_REG_STATUS, 32'h0000_0020);
    av(0, PPEC_REG_STATUS, 32'h0000_0000);
    check({31'h0, rd[5]}, 32'h0000_0000);
    rd_byte(18'h0_0110, 8'h55);
    op(PPEC_CMD_LOCK, 18'h0_0000, 8'h00);
    stat_wait(32'h0000_001A);
    check({31'h0, locked}, 32'h0000_0001);
    av(0, PPEC_REG_STATUS, 32'h0000_0000);
    check({31'h0, rd[6]}, 32'h0000_0001);
    op(PPEC_CMD_LOAD, 18'h0_0200, 8'h3C);
    rd_byte(18'h0_0200, 8'hFF);
    op(PPEC_CMD_PLOAD, 18'h0_0200, 8'h3C);
    rd_byte(18'h0_0200, 8'h3C);
    rd_byte({1'b0, PPEC_SEQ_A0}, 8'hFF);
    op(PPEC_CMD_UNLOCK, 18'h0_0000, 8'h00);
    stat_wait(32'h0000_001A);
    check({31'h0, locked}, 32'h0000_0000);
    av(0, PPEC_REG_STATUS, 32'h0000_0000);
    check({31'h0, rd[6]}, 32'h0000_0000);
    op(PPEC_CMD_LOAD, 18'h0_0200, 8'h5A);
    rd_byte(18'h0_0200, 8'h5A);
    op(PPEC_CMD_LOAD, 18'h3_FF85, 8'h77);
    rd_byte(18'h3_FF85, 8'h77);
    rd_byte(18'h1_FF85, 8'hFF);
    tally_and_finish();
  end
endmodule
bind ppec_host ppec_host_assertions #(.PWRUP_CYC(PWRUP_CYC)) ppec_host_assertions_inst (
  .i_sys_clk(i_sys_clk), .i_reset(i_reset), .o_mem(o_mem), .o_mem_data(o_mem_data),
  .o_mem_data_oe(o_mem_data_oe));
`default_nettype wire
